// file: logic/pwpl_top.sv
// Functional notes
// - a one in a wake-enable bit turns partial wake-up on; zero does nothing
// - a one in a wake-disable bit turns partial wake-up off; zero does nothing
// - only serial and fast two-wire units hold wake-up state; others stay off
// - enable, disable and ceiling writes are ignored while write protect is set
// - wake status reads one while partial wake-up is enabled
// - status reads zero when disabled and clears itself on wake-up detection
// - activity bit of an id 0 to 31 reads one while the peripheral is busy; higher ids have none
// - activity bit reads zero while the peripheral is idle
// - activity bits of peripherals without wake-up always read zero
// - multiplier to the pll is saturated at the ceiling value
// - ceiling write dropped while the current multiplier is being clamped
// - ceiling write dropped when the new ceiling is below the multiplier
`timescale 1ns/100ps
`default_nettype none

module pwpl_top
    import pwpl_pkg::*;
(
    input  wire logic                   sys_clk_i,
    input  wire logic                   reset_i,
    input  wire logic [PWPL_DATA_W-1:0] reg_addr_i,
    input  wire logic [PWPL_DATA_W-1:0] reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [PWPL_DATA_W-1:0] reg_rdata_o,
    input  wire logic                   write_protect_enable_i,
    input  wire logic [PWPL_PID_N-1:0]  periph_busy_i,
    input  wire logic [PWPL_PID_N-1:0]  wake_detect_i,
    input  wire logic [PWPL_MUL_W-1:0]  pll_multiplier_i,
    output logic      [PWPL_PID_N-1:0]  wake_enable_o,
    output logic      [PWPL_MUL_W-1:0]  pll_multiplier_o
);

    // ***********************************************************
    // write decode
    // ***********************************************************
    logic                  wr_ok;
    logic                  wr_en_lo;
    logic                  wr_en_hi;
    logic                  wr_dis_lo;
    logic                  wr_dis_hi;
    logic                  wr_ceil;
    logic [PWPL_PID_N-1:0] set_vec;
    logic [PWPL_PID_N-1:0] clr_vec;

    always_comb
    begin
        wr_ok     = reg_wr_i && !write_protect_enable_i;
        wr_en_lo  = wr_ok && (reg_addr_i == PWPL_ADDR_WAKE_EN_LO);
        wr_en_hi  = wr_ok && (reg_addr_i == PWPL_ADDR_WAKE_EN_HI);
        wr_dis_lo = wr_ok && (reg_addr_i == PWPL_ADDR_WAKE_DIS_LO);
        wr_dis_hi = wr_ok && (reg_addr_i == PWPL_ADDR_WAKE_DIS_HI);
        wr_ceil   = wr_ok && (reg_addr_i == PWPL_ADDR_CEILING);
        set_vec   = '0;
        clr_vec   = '0;
        if (wr_en_lo || wr_en_hi)
        begin
            set_vec = pwpl_place(reg_wdata_i, wr_en_hi);
        end
        if (wr_dis_lo || wr_dis_hi)
        begin
            clr_vec = pwpl_place(reg_wdata_i, wr_dis_hi);
        end
    end

    // ***********************************************************
    // wake-up enable state
    // ***********************************************************
    logic [PWPL_PID_N-1:0] wake_ff;
    logic [PWPL_PID_N-1:0] nxt_wake;

    always_comb
    begin
        // enable wins over a detection in the same cycle
        nxt_wake = ((wake_ff & ~clr_vec & ~wake_detect_i) | set_vec)
                 & PWPL_WAKE_CAP;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wake_ff <= '0;
        end
        else
        begin
            wake_ff <= nxt_wake;
        end
    end

    assign wake_enable_o = wake_ff;

    // ***********************************************************
    // activity status
    // ***********************************************************
    logic [PWPL_DATA_W-1:0] act_ff;
    logic [PWPL_DATA_W-1:0] nxt_act;

    always_comb
    begin
        nxt_act = periph_busy_i[PWPL_DATA_W-1:0] & PWPL_WAKE_CAP[PWPL_DATA_W-1:0];
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            act_ff <= '0;
        end
        else
        begin
            act_ff <= nxt_act;
        end
    end

    // ***********************************************************
    // pll multiplier ceiling
    // ***********************************************************
    logic [PWPL_MUL_W-1:0] ceiling;

    pwpl_ceiling u_ceiling
    (
        .sys_clk_i        (sys_clk_i),
        .reset_i          (reset_i),
        .ceil_wr_i        (wr_ceil),
        .ceil_wdata_i     (reg_wdata_i[PWPL_MUL_W-1:0]),
        .pll_multiplier_i (pll_multiplier_i),
        .ceiling_o        (ceiling),
        .pll_multiplier_o (pll_multiplier_o)
    );

    // ***********************************************************
    // read path
    // ***********************************************************
    logic [PWPL_DATA_W-1:0] rdata_ff;
    logic [PWPL_DATA_W-1:0] nxt_rdata;

    always_comb
    begin
        nxt_rdata = '0;
        if (reg_rd_i)
        begin
            unique case (reg_addr_i)
                PWPL_ADDR_WAKE_ST_LO:
                begin
                    nxt_rdata = wake_ff[PWPL_DATA_W-1:0];
                end
                PWPL_ADDR_WAKE_ST_HI:
                begin
                    nxt_rdata = wake_ff[PWPL_PID_N-1:PWPL_DATA_W];
                end
                PWPL_ADDR_ACT_LO:
                begin
                    nxt_rdata = act_ff;
                end
                PWPL_ADDR_CEILING:
                begin
                    nxt_rdata = {{(PWPL_DATA_W-PWPL_MUL_W){1'b0}}, ceiling};
                end
                default:
                begin
                    nxt_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            rdata_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign reg_rdata_o = rdata_ff;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (reset_i);

    sequence s_enable_lo;
        reg_wr_i && !write_protect_enable_i && (reg_addr_i == PWPL_ADDR_WAKE_EN_LO);
    endsequence

    sequence s_disable_hi;
        reg_wr_i && !write_protect_enable_i && (reg_addr_i == PWPL_ADDR_WAKE_DIS_HI);
    endsequence

    sequence s_protected_write;
        reg_wr_i && write_protect_enable_i;
    endsequence

    sequence s_enable_hi;
        reg_wr_i && !write_protect_enable_i && (reg_addr_i == PWPL_ADDR_WAKE_EN_HI);
    endsequence

    sequence s_disable_lo;
        reg_wr_i && !write_protect_enable_i && (reg_addr_i == PWPL_ADDR_WAKE_DIS_LO);
    endsequence

    sequence s_status_lo_read;
        reg_rd_i && (reg_addr_i == PWPL_ADDR_WAKE_ST_LO);
    endsequence

    sequence s_ceiling_read;
        reg_rd_i && (reg_addr_i == PWPL_ADDR_CEILING);
    endsequence

    chk_enable_sets_bits: assert property (
        s_enable_lo |=> ((wake_enable_o[PWPL_DATA_W-1:0] & $past(reg_wdata_i) & PWPL_WAKE_CAP[PWPL_DATA_W-1:0])
                        == ($past(reg_wdata_i) & PWPL_WAKE_CAP[PWPL_DATA_W-1:0])))
        else $error("enable write did not set wake bits");

    chk_enable_keeps_zero: assert property (
        s_enable_lo and !(|wake_detect_i) |=> (($past(wake_enable_o) & ~wake_enable_o) == '0))
        else $error("zero in enable write cleared a bit");

    chk_disable_clears: assert property (
        s_disable_hi and !(|set_vec) |=> ((wake_enable_o[PWPL_PID_N-1:PWPL_DATA_W] & $past(reg_wdata_i)) == '0))
        else $error("disable write left wake bits on");

    chk_incapable_off: assert property (
        (wake_enable_o & ~PWPL_WAKE_CAP) == '0)
        else $error("wake bit set on incapable peripheral");

    chk_protect_blocks: assert property (
        s_protected_write and !(|wake_detect_i) |=> $stable(wake_enable_o) && $stable(ceiling))
        else $error("write accepted under write protect");

    chk_status_read: assert property (
        reg_rd_i && (reg_addr_i == PWPL_ADDR_WAKE_ST_HI)
        |=> reg_rdata_o == $past(wake_enable_o[PWPL_PID_N-1:PWPL_DATA_W]))
        else $error("high status read mismatch");

    chk_detect_clears: assert property (
        (|(wake_detect_i & wake_enable_o & ~set_vec)) |=> ((wake_enable_o & $past(wake_detect_i & ~set_vec)) == '0))
        else $error("wake detection did not clear status");

    chk_activity_read: assert property (
        reg_rd_i && (reg_addr_i == PWPL_ADDR_ACT_LO)
        |=> reg_rdata_o == ($past(periph_busy_i[PWPL_DATA_W-1:0], 2) & PWPL_WAKE_CAP[PWPL_DATA_W-1:0]))
        else $error("activity read does not follow busy");

    chk_activity_masked: assert property (
        (act_ff & ~PWPL_WAKE_CAP[PWPL_DATA_W-1:0]) == '0)
        else $error("activity bit on incapable peripheral");

    chk_read_idle_zero: assert property (
        !reg_rd_i |=> reg_rdata_o == '0)
        else $error("read data present without read");

    chk_enable_hi_sets: assert property (
        s_enable_hi |=> ((wake_enable_o[PWPL_PID_N-1:PWPL_DATA_W] & $past(reg_wdata_i)
                         & PWPL_WAKE_CAP[PWPL_PID_N-1:PWPL_DATA_W])
                        == ($past(reg_wdata_i) & PWPL_WAKE_CAP[PWPL_PID_N-1:PWPL_DATA_W])))
        else $error("high enable write did not set wake bits");

    chk_disable_lo_clears: assert property (
        s_disable_lo |=> ((wake_enable_o[PWPL_DATA_W-1:0] & $past(reg_wdata_i)) == '0))
        else $error("low disable write left wake bits on");

    chk_disable_no_set: assert property (
        s_disable_lo or s_disable_hi |=> ((~$past(wake_enable_o) & wake_enable_o) == '0))
        else $error("disable write turned a wake bit on");

    chk_only_enable_sets: assert property (
        !(wr_en_lo || wr_en_hi) |=> ((~$past(wake_enable_o) & wake_enable_o) == '0))
        else $error("wake bit set without enable write");

    chk_status_lo_read: assert property (
        s_status_lo_read
        |=> reg_rdata_o == $past(wake_enable_o[PWPL_DATA_W-1:0]))
        else $error("low status read mismatch");

    chk_ceiling_read: assert property (
        s_ceiling_read
        |=> reg_rdata_o == {{(PWPL_DATA_W-PWPL_MUL_W){1'b0}}, $past(ceiling)})
        else $error("ceiling read mismatch");

    chk_write_only_zero: assert property (
        reg_rd_i && ((reg_addr_i == PWPL_ADDR_WAKE_EN_LO) || (reg_addr_i == PWPL_ADDR_WAKE_EN_HI)
                     || (reg_addr_i == PWPL_ADDR_WAKE_DIS_LO) || (reg_addr_i == PWPL_ADDR_WAKE_DIS_HI))
        |=> reg_rdata_o == '0)
        else $error("write-only register read nonzero");

    chk_clear_needs_cause: assert property (
        !(wr_dis_lo || wr_dis_hi) && !(|wake_detect_i)
        |=> (($past(wake_enable_o) & ~wake_enable_o) == '0))
        else $error("wake bit cleared without cause");

    chk_activity_idle: assert property (
        reg_rd_i && (reg_addr_i == PWPL_ADDR_ACT_LO) && ($past(periph_busy_i[PWPL_DATA_W-1:0]) == '0)
        |=> reg_rdata_o == '0)
        else $error("idle peripheral reads active");

endmodule

`default_nettype wire

// file: logic/pwpl_pkg.sv
`default_nettype none

package pwpl_pkg;

    // ***********************************************************
    // register byte addresses
    // ***********************************************************
    localparam logic [31:0] PWPL_ADDR_WAKE_EN_LO  = 32'h400e0714;
    localparam logic [31:0] PWPL_ADDR_WAKE_DIS_LO = 32'h400e0718;
    localparam logic [31:0] PWPL_ADDR_WAKE_ST_LO  = 32'h400e071c;
    localparam logic [31:0] PWPL_ADDR_ACT_LO      = 32'h400e0720;
    localparam logic [31:0] PWPL_ADDR_CEILING     = 32'h400e0730;
    localparam logic [31:0] PWPL_ADDR_WAKE_EN_HI  = 32'h400e0734;
    localparam logic [31:0] PWPL_ADDR_WAKE_DIS_HI = 32'h400e0738;
    localparam logic [31:0] PWPL_ADDR_WAKE_ST_HI  = 32'h400e073c;

    // ***********************************************************
    // widths, field layouts and reset values
    // ***********************************************************
    localparam int unsigned PWPL_DATA_W = 32;
    localparam int unsigned PWPL_PID_N  = 64;
    localparam int unsigned PWPL_MUL_W  = 11;

    localparam logic [PWPL_MUL_W-1:0]  PWPL_CEIL_RESET = 11'h7ff;
    localparam logic [PWPL_DATA_W-1:0] PWPL_ZERO_WORD  = 32'h0000_0000;
    localparam logic [PWPL_PID_N-1:0]  PWPL_IMPL_MASK  = 64'h1f3f_ffaf_ffff_ff80;
    localparam logic [PWPL_PID_N-1:0]  PWPL_WAKE_CAP   = 64'h0000_7200_0018_0180;

    // ***********************************************************
    // helpers
    // ***********************************************************
    function automatic logic [PWPL_PID_N-1:0] pwpl_place(
        input logic [PWPL_DATA_W-1:0] data,
        input logic                   high
    );
        return high ? {data, PWPL_ZERO_WORD} : {PWPL_ZERO_WORD, data};
    endfunction

    function automatic logic pwpl_is_clamped(
        input logic [PWPL_MUL_W-1:0] mul,
        input logic [PWPL_MUL_W-1:0] ceil
    );
        return mul > ceil;
    endfunction

endpackage

`default_nettype wire

// file: logic/pwpl_ceiling.sv
`timescale 1ns/100ps
`default_nettype none

module pwpl_ceiling
    import pwpl_pkg::*;
(
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    input  wire logic                  ceil_wr_i,
    input  wire logic [PWPL_MUL_W-1:0] ceil_wdata_i,
    input  wire logic [PWPL_MUL_W-1:0] pll_multiplier_i,
    output logic      [PWPL_MUL_W-1:0] ceiling_o,
    output logic      [PWPL_MUL_W-1:0] pll_multiplier_o
);

    // ***********************************************************
    // ceiling register and clamp
    // ***********************************************************
    logic [PWPL_MUL_W-1:0] ceil_ff;
    logic [PWPL_MUL_W-1:0] nxt_ceil;
    logic [PWPL_MUL_W-1:0] mul_ff;
    logic [PWPL_MUL_W-1:0] nxt_mul;
    logic                  accept;

    always_comb
    begin
        accept = ceil_wr_i
               && !pwpl_is_clamped(pll_multiplier_i, ceil_ff)
               && (ceil_wdata_i >= pll_multiplier_i);
        nxt_ceil = accept ? ceil_wdata_i : ceil_ff;
        nxt_mul  = pwpl_is_clamped(pll_multiplier_i, ceil_ff) ? ceil_ff : pll_multiplier_i;
    end

    always_ff @(posedge sys_clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            ceil_ff <= PWPL_CEIL_RESET;
            mul_ff  <= '0;
        end
        else
        begin
            ceil_ff <= nxt_ceil;
            mul_ff  <= nxt_mul;
        end
    end

    assign ceiling_o        = ceil_ff;
    assign pll_multiplier_o = mul_ff;

    // ***********************************************************
    // checks
    // ***********************************************************
    chk_clamp_limit: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ##1 pll_multiplier_o == (($past(pll_multiplier_i) > $past(ceil_ff))
                                 ? $past(ceil_ff) : $past(pll_multiplier_i)))
        else $error("multiplier not clamped to ceiling");

    chk_clamped_discard: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ceil_wr_i && (pll_multiplier_i > ceil_ff) |=> $stable(ceil_ff))
        else $error("ceiling changed while clamping");

    chk_small_discard: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ceil_wr_i && (ceil_wdata_i < pll_multiplier_i) |=> $stable(ceil_ff))
        else $error("ceiling below multiplier accepted");

    chk_ceiling_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        ceil_wr_i && (pll_multiplier_i <= ceil_ff) && (ceil_wdata_i >= pll_multiplier_i)
        |=> ceil_ff == $past(ceil_wdata_i))
        else $error("legal ceiling write lost");

endmodule

`default_nettype wire

// file: sim/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench
    import pwpl_pkg::*;
;

    // ***********************************************************
    // signals and design instance
    // ***********************************************************
    logic                   sys_clk;
    logic                   reset;
    logic [PWPL_DATA_W-1:0] reg_addr;
    logic [PWPL_DATA_W-1:0] reg_wdata;
    logic                   reg_wr;
    logic                   reg_rd;
    logic [PWPL_DATA_W-1:0] reg_rdata;
    logic                   wp_en;
    logic [PWPL_PID_N-1:0]  busy;
    logic [PWPL_PID_N-1:0]  detect;
    logic [PWPL_MUL_W-1:0]  mul_in;
    logic [PWPL_PID_N-1:0]  wake_en;
    logic [PWPL_MUL_W-1:0]  mul_out;
    logic [PWPL_PID_N-1:0]  exp_en;
    int                     failures;
    int                     check_count;

    pwpl_top DUT (
        .sys_clk_i              (sys_clk),
        .reset_i                (reset),
        .reg_addr_i             (reg_addr),
        .reg_wdata_i            (reg_wdata),
        .reg_wr_i               (reg_wr),
        .reg_rd_i               (reg_rd),
        .reg_rdata_o            (reg_rdata),
        .write_protect_enable_i (wp_en),
        .periph_busy_i          (busy),
        .wake_detect_i          (detect),
        .pll_multiplier_i       (mul_in),
        .wake_enable_o          (wake_en),
        .pll_multiplier_o       (mul_out)
    );

    always #5 sys_clk = ~sys_clk;

    // ***********************************************************
    // compare, bus and closing tasks
    // ***********************************************************
    task automatic check_bits(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_mul(input string name, input logic [10:0] exp, input logic [10:0] got);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic reg_write(input logic [31:0] addr, input logic [31:0] data);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= addr;
        reg_wdata <= data;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic read_expect(input logic [31:0] addr, input logic [31:0] exp, input string name);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= addr;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        #1;
        check_word(name, exp, reg_rdata);
    endtask

    task automatic give_verdict;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ***********************************************************
    // watchdog, tests need well under a thousand cycles
    // ***********************************************************
    initial
    begin
        #20000;
        failures++;
        $display("watchdog expired");
        give_verdict;
    end

    // ***********************************************************
    // test sequence
    // ***********************************************************
    initial
    begin
        sys_clk = 1'b0;
        reset = 1'b1;
        reg_addr = 32'h0;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        wp_en = 1'b0;
        busy = 64'h0;
        detect = 64'h0;
        mul_in = 11'h000;
        failures = 0;
        check_count = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        #1;
        check_bits("wake_enable", 64'h0, wake_en);
        check_mul("pll_multiplier", 11'h000, mul_out);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_07ff, "ceiling");
        // enable every id, only capable ones stick; peripheral clocks taken as running
        reg_write(PWPL_ADDR_WAKE_EN_LO, 32'hffff_ffff);
        reg_write(PWPL_ADDR_WAKE_EN_HI, 32'hffff_ffff);
        #1;
        check_bits("wake_enable", PWPL_WAKE_CAP, wake_en);
        read_expect(PWPL_ADDR_WAKE_ST_LO, PWPL_WAKE_CAP[31:0], "status_lo");
        read_expect(PWPL_ADDR_WAKE_ST_HI, PWPL_WAKE_CAP[63:32], "status_hi");
        read_expect(PWPL_ADDR_WAKE_EN_LO, 32'h0, "enable_lo");
        read_expect(32'h400e0724, 32'h0, "unmapped");
        // zero writes leave state alone, ones clear
        reg_write(PWPL_ADDR_WAKE_EN_LO, 32'h0);
        reg_write(PWPL_ADDR_WAKE_DIS_LO, 32'h0);
        reg_write(PWPL_ADDR_WAKE_DIS_LO, 32'h0000_0080);
        reg_write(PWPL_ADDR_WAKE_DIS_HI, 32'h0000_0200);
        exp_en = PWPL_WAKE_CAP & ~64'h0000_0200_0000_0080;
        #1;
        check_bits("wake_enable", exp_en, wake_en);
        read_expect(PWPL_ADDR_WAKE_ST_HI, exp_en[63:32], "status_hi");
        // protected writes dropped
        @(posedge sys_clk);
        wp_en <= 1'b1;
        reg_write(PWPL_ADDR_WAKE_EN_LO, 32'hffff_ffff);
        reg_write(PWPL_ADDR_WAKE_DIS_HI, 32'hffff_ffff);
        reg_write(PWPL_ADDR_CEILING, 32'h0000_0100);
        wp_en <= 1'b0;
        #1;
        check_bits("wake_enable", exp_en, wake_en);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_07ff, "ceiling");
        // wake detection clears its own bit
        @(posedge sys_clk);
        detect <= 64'h0000_0000_0000_0100;
        @(posedge sys_clk);
        detect <= 64'h0;
        #1;
        exp_en[8] = 1'b0;
        check_bits("wake_enable", exp_en, wake_en);
        // activity reporting
        @(posedge sys_clk);
        busy <= 64'hffff_ffff_ffff_ffff;
        repeat (3) @(posedge sys_clk);
        read_expect(PWPL_ADDR_ACT_LO, PWPL_WAKE_CAP[31:0], "activity_lo");
        @(posedge sys_clk);
        busy <= 64'h0;
        repeat (3) @(posedge sys_clk);
        read_expect(PWPL_ADDR_ACT_LO, 32'h0, "activity_lo");
        // multiplier ceiling
        @(posedge sys_clk);
        mul_in <= 11'h050;
        reg_write(PWPL_ADDR_CEILING, 32'h0000_0100);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_0100, "ceiling");
        @(posedge sys_clk);
        mul_in <= 11'h200;
        repeat (2) @(posedge sys_clk);
        #1;
        check_mul("pll_multiplier", 11'h100, mul_out);
        reg_write(PWPL_ADDR_CEILING, 32'h0000_0300);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_0100, "ceiling");
        @(posedge sys_clk);
        mul_in <= 11'h080;
        reg_write(PWPL_ADDR_CEILING, 32'h0000_0040);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_0100, "ceiling");
        reg_write(PWPL_ADDR_CEILING, 32'hffff_f0c0);
        read_expect(PWPL_ADDR_CEILING, 32'h0000_00c0, "ceiling");
        #1;
        check_mul("pll_multiplier", 11'h080, mul_out);
        give_verdict;
    end

endmodule

`default_nettype wire
